// ===== hw/spi_ctrl.sv
// Purpose: SPI control and configuration with a small byte engine behind AHB-Lite
// Assumes: 125 MHz hclk; serial pins asynchronous and synchronised here
// Notes:   Pin order {ss, miso, mosi, sck}; output enable high while driving
// Functional notes
// R01: Receive-full or mode-fault raises the interrupt while the receive/fault enable is set.
// R02: Clearing enable aborts transfer, empties buffers, idles engine, sets transmit-empty.
// R03: Transmit-empty raises the interrupt while the transmit enable is set.
// R04: Master select zero makes a slave, one makes a master.
// R05: Polarity bit inverts serial clock; zero idles low, one idles high.
// R06: Phase zero puts first edge mid bit; phase one at bit start.
// R07: Bit order zero shifts MSB first, one shifts LSB first.
// R08: Master without fault detect releases the select pin.
// R09: Master with fault detect: select is fault input or automatic output.
// R10: In slave mode the select pin is always the active-low input.
// R11: Software must not disable and change phase in one write.
// R12: Unimplemented secondary control bits 7, 6, 5 and 2 read zero.
// R13: In single-wire mode the shared output enable drives or releases the pin.
// R14: With separate pins the shared output enable has no effect.
// R15: Wait-stop bit freezes the engine while the processor waits.
// R16: Single-wire mode uses one shared pin, chosen by master or slave.
// R17: While disabled all four serial pins are released.
// R18: Moving a byte into the shifter sets transmit-empty.
// R19: The interrupt output ORs all enabled conditions.
`include "spi_ctrl_defines.svh"
module spi_ctrl
    import spi_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Serial pins {ss, miso, mosi, sck}
    input  wire logic [3:0]  pin_in,
    output logic [3:0]       pin_out,
    output logic [3:0]       pin_oe,
    // System
    input  wire logic        cpu_wait_mode,
    output logic             irq
);
    ctrl_state_s st_ff;
    ctrl_state_s nxt_st;
    logic [3:0]  pin_q;
    logic        en;
    logic        mst;
    logic        phase;
    logic        single;
    logic        frozen;
    logic        din;
    logic        fault;
    logic        acc;

    localparam ctrl_state_s ST_RST = '{c1: `PRIMARY_RST, c2: `SECONDARY_RST,
        baud: `BAUD_RST, state: ST_IDLE, hreadyout: 1'h1, sck_prev: 1'h0,
        ss_prev: 1'h1, default: '0};

    // Outgoing bit of the shifter for the chosen order
    function automatic logic out_bit(input logic [7:0] sh, input logic lsb);
        return lsb ? sh[0] : sh[7];
    endfunction

    // Shift one received bit in from the far end
    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic lsb,
                                            input logic d);
        return lsb ? {d, sh[7:1]} : {sh[6:0], d};
    endfunction

    spi_pin_sync u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin_raw (pin_in),
        .pin_q   (pin_q)
    );

    // Decoded control bits
    assign en     = st_ff.c1[`B_SYS_EN];
    assign mst    = st_ff.c1[`B_MASTER];
    assign phase  = st_ff.c1[`B_PHASE];
    assign single = st_ff.c2[`B_SINGLE_WIRE];
    assign frozen = st_ff.c2[`B_WAIT_STOP] & cpu_wait_mode;
    // Data input pin by role and pin mode
    assign din    = (mst ^ single) ? pin_q[`PIN_MISO] : pin_q[`PIN_MOSI];
    // Select low while a master watches it for faults
    assign fault  = en & mst & st_ff.c2[`B_FAULT_DET_EN] & ~st_ff.c1[`B_SEL_OUT_EN]
                  & ~pin_q[`PIN_SS];
    assign acc    = hsel & htrans[1] & hready;

    // Next state: bus, engine, fault, disable, then pins and interrupt
    always_comb begin
        logic       edge_ev;
        logic       load;
        logic [4:0] k;
        edge_ev = 1'h0;
        load    = 1'h0;
        k       = '0;
        nxt_st  = st_ff;
        // Address phase; reads take one wait state so data leaves a flop
        nxt_st.a_sel     = acc;
        nxt_st.a_write   = hwrite;
        nxt_st.a_addr    = haddr[7:0];
        nxt_st.rd_pend   = acc & ~hwrite;
        nxt_st.hreadyout = ~(acc & ~hwrite);
        nxt_st.sck_prev  = pin_q[`PIN_SCK];
        nxt_st.ss_prev   = pin_q[`PIN_SS];
        // Data phase write; unmapped offsets are ignored
        if (st_ff.a_sel && st_ff.a_write) begin
            case (st_ff.a_addr)
                `OFS_PRIMARY: begin
                    nxt_st.c1 = hwdata[7:0];
                end
                `OFS_SECONDARY: begin
                    nxt_st.c2 = hwdata[7:0] & `SECONDARY_MASK; // [R12]
                end
                `OFS_STATUS: begin
                    if (hwdata[`B_MODE_FAULT]) begin
                        nxt_st.mode_fault_flag = 1'h0;
                    end
                end
                `OFS_DATA: begin
                    if (!st_ff.tx_full && en) begin
                        nxt_st.txbuf   = hwdata[7:0];
                        nxt_st.tx_full = 1'h1;
                    end
                end
                `OFS_BAUD: begin
                    nxt_st.baud = hwdata[7:0];
                end
                default: begin
                end
            endcase
        end
        // Read data; unmapped offsets read zero
        if (st_ff.rd_pend) begin
            case (st_ff.a_addr)
                `OFS_PRIMARY:   nxt_st.hrdata = {24'h0, st_ff.c1};
                `OFS_SECONDARY: nxt_st.hrdata = {24'h0, st_ff.c2 & `SECONDARY_MASK}; // [R12]
                `OFS_STATUS:    nxt_st.hrdata = {24'h0, st_ff.rx_full, 1'h0, ~st_ff.tx_full,
                                                 st_ff.mode_fault_flag, 4'h0};
                `OFS_DATA: begin
                    nxt_st.hrdata  = {24'h0, st_ff.rxbuf};
                    nxt_st.rx_full = 1'h0;
                end
                `OFS_BAUD:      nxt_st.hrdata = {24'h0, st_ff.baud};
                default:        nxt_st.hrdata = '0;
            endcase
        end
        // Engine; wait-stop holds every counter where it is
        if (en && !frozen) begin // [R15]
            if (mst) begin // [R04]
                if (st_ff.state == ST_IDLE) begin
                    if (st_ff.tx_full && !fault) begin
                        load            = 1'h1;
                        nxt_st.state    = ST_XFER;
                        nxt_st.edge_cnt = '0;
                        // Phase one clocks right away, phase zero waits half a bit
                        nxt_st.div_cnt  = phase ? 8'h00 : st_ff.baud; // [R06]
                    end
                end else if (st_ff.div_cnt == 8'h00) begin
                    nxt_st.div_cnt  = st_ff.baud;
                    nxt_st.sclk_lvl = ~st_ff.sclk_lvl;
                    edge_ev         = 1'h1;
                end else begin
                    nxt_st.div_cnt = st_ff.div_cnt - 8'h01;
                end
            end else if (!pin_q[`PIN_SS]) begin // [R10]
                if (st_ff.ss_prev) begin
                    load            = 1'h1;
                    nxt_st.edge_cnt = '0;
                end else if (pin_q[`PIN_SCK] != st_ff.sck_prev) begin
                    edge_ev = 1'h1;
                end
            end else begin
                nxt_st.edge_cnt = '0;
            end
        end
        // Odd edges sample for phase zero, even edges for phase one
        if (edge_ev) begin
            k               = st_ff.edge_cnt + 5'h01;
            nxt_st.edge_cnt = k;
            if (k[0] ^ phase) begin // [R06]
                nxt_st.shreg = shift_in(st_ff.shreg, st_ff.c1[`B_LSB_FIRST], din); // [R07]
            end else begin
                nxt_st.dout = out_bit(st_ff.shreg, st_ff.c1[`B_LSB_FIRST]); // [R07]
            end
            if (k == `XFER_EDGES) begin
                nxt_st.rxbuf    = nxt_st.shreg;
                nxt_st.rx_full  = 1'h1;
                nxt_st.edge_cnt = '0;
                nxt_st.state    = ST_IDLE;
                load            = ~mst;
            end
        end
        // Buffer to shifter move frees the transmit buffer
        if (load && st_ff.tx_full) begin
            nxt_st.shreg   = st_ff.txbuf;
            nxt_st.tx_full = 1'h0; // [R18]
            nxt_st.dout    = out_bit(st_ff.txbuf, st_ff.c1[`B_LSB_FIRST]); // [R07]
        end
        // Fault wins over a same-cycle clear and drops the master role
        if (fault) begin
            nxt_st.mode_fault_flag                = 1'h1;
            nxt_st.c1[`B_MASTER]       = 1'h0;
            nxt_st.state               = ST_IDLE;
            nxt_st.sclk_lvl            = 1'h0;
            nxt_st.edge_cnt            = '0;
        end
        // Disabled: everything back to its idle form
        if (!nxt_st.c1[`B_SYS_EN]) begin
            nxt_st.state    = ST_IDLE; // [R02]
            nxt_st.tx_full  = 1'h0;
            nxt_st.rx_full  = 1'h0;
            nxt_st.edge_cnt = '0;
            nxt_st.div_cnt  = '0;
            nxt_st.sclk_lvl = 1'h0;
        end
        // Pin drive from the next state so pins leave flops
        nxt_st.pin_oe = '0; // [R17]
        nxt_st.pin_o  = '0;
        if (nxt_st.c1[`B_SYS_EN]) begin
            if (nxt_st.c1[`B_MASTER]) begin
                nxt_st.pin_oe[`PIN_SCK]  = 1'h1;
                nxt_st.pin_o[`PIN_SCK]   = nxt_st.c1[`B_POLARITY] ^ nxt_st.sclk_lvl; // [R05]
                nxt_st.pin_oe[`PIN_MOSI] = ~nxt_st.c2[`B_SINGLE_WIRE]
                                         | nxt_st.c2[`B_SHARED_OE]; // [R13] [R14] [R16]
                // Automatic select only with fault detect and output enable
                nxt_st.pin_oe[`PIN_SS]   = nxt_st.c2[`B_FAULT_DET_EN]
                                         & nxt_st.c1[`B_SEL_OUT_EN]; // [R08] [R09]
                // Select rises a cycle after the last edge so the far end still sees it
                nxt_st.pin_o[`PIN_SS]    = (nxt_st.state != ST_XFER)
                                         && (st_ff.state != ST_XFER);
            end else if (nxt_st.c2[`B_SINGLE_WIRE]) begin
                nxt_st.pin_oe[`PIN_MISO] = nxt_st.c2[`B_SHARED_OE]; // [R13] [R16]
            end else begin
                // Separate pins: a slave drives only while selected
                nxt_st.pin_oe[`PIN_MISO] = ~pin_q[`PIN_SS]; // [R14]
            end
        end
        nxt_st.pin_o[`PIN_MOSI] = nxt_st.dout;
        nxt_st.pin_o[`PIN_MISO] = nxt_st.dout;
        nxt_st.irq = (nxt_st.c1[`B_RX_FAULT_IE] & (nxt_st.rx_full | nxt_st.mode_fault_flag)) // [R01]
                   | (nxt_st.c1[`B_TX_EMPTY_IE] & ~nxt_st.tx_full); // [R03] [R19]
    end

    // Single state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign hreadyout = st_ff.hreadyout;
    assign hrdata    = st_ff.hrdata;
    assign hresp     = 1'h0; // Always OKAY
    assign pin_out   = st_ff.pin_o;
    assign pin_oe    = st_ff.pin_oe;
    assign irq       = st_ff.irq;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    rx_irq_a: assert property ((st_ff.c1[`B_RX_FAULT_IE] && (st_ff.rx_full || st_ff.mode_fault_flag)) // [R01]
        |-> irq) else $error("receive or fault interrupt missing");
    disable_clear_a: assert property (!en |-> (!st_ff.tx_full && !st_ff.rx_full // [R02]
        && st_ff.state == ST_IDLE)) else $error("disable left engine busy");
    tx_irq_a: assert property ((st_ff.c1[`B_TX_EMPTY_IE] && !st_ff.tx_full) |-> irq) // [R03]
        else $error("transmit empty interrupt missing");
    irq_src_a: assert property (irq |-> (st_ff.c1[`B_TX_EMPTY_IE] // [R19]
        || (st_ff.c1[`B_RX_FAULT_IE] && (st_ff.rx_full || st_ff.mode_fault_flag))))
        else $error("interrupt without enabled cause");
    idle_clock_a: assert property ((en && mst && st_ff.state == ST_IDLE) // [R05]
        |-> (pin_oe[`PIN_SCK] && pin_out[`PIN_SCK] == st_ff.c1[`B_POLARITY]))
        else $error("master clock not at idle level");
    ss_release_a: assert property ((en && mst && !st_ff.c2[`B_FAULT_DET_EN]) // [R08]
        |-> !pin_oe[`PIN_SS]) else $error("select pin driven without fault detect");
    ss_auto_a: assert property ((en && mst && st_ff.c2[`B_FAULT_DET_EN] // [R09]
        && st_ff.c1[`B_SEL_OUT_EN] && st_ff.state == ST_XFER)
        |-> (pin_oe[`PIN_SS] && !pin_out[`PIN_SS])) else $error("automatic select not low");
    slave_ss_a: assert property ((en && !mst) |-> (!pin_oe[`PIN_SS] && !pin_oe[`PIN_SCK])) // [R10]
        else $error("slave drives select or clock");
    c2_zero_a: assert property ((st_ff.rd_pend && st_ff.a_addr == `OFS_SECONDARY) // [R12]
        |=> (hrdata[7:5] == 3'h0 && !hrdata[2])) else $error("reserved bits read nonzero");
    shared_pin_a: assert property ((en && mst && single) // [R13]
        |-> (pin_oe[`PIN_MOSI] == st_ff.c2[`B_SHARED_OE] && !pin_oe[`PIN_MISO]))
        else $error("shared pin drive wrong");
    wait_hold_a: assert property ((frozen && st_ff.state == ST_XFER) ##1 frozen // [R15]
        |-> $stable(st_ff.edge_cnt)) else $error("engine moved in wait stop");
    released_a: assert property (!en |-> pin_oe == 4'h0) // [R17]
        else $error("pins driven while disabled");
    tx_move_a: assert property ((en && mst && !frozen && !fault // [R18]
        && st_ff.state == ST_IDLE && st_ff.tx_full) |=> (!st_ff.tx_full
        && st_ff.state == ST_XFER)) else $error("buffer not moved to shifter");

    master_done_c: cover property (mst && st_ff.state == ST_XFER ##1 !st_ff.rx_full
        ##[1:1000] st_ff.rx_full);
    slave_done_c: cover property (en && !mst && !st_ff.rx_full ##1 st_ff.rx_full);
    fault_c: cover property (!st_ff.mode_fault_flag ##1 st_ff.mode_fault_flag);
    wait_c: cover property (frozen && st_ff.state == ST_XFER);
endmodule

// ===== inc/spi_ctrl_defines.svh
// Purpose: Offsets, bit positions, reset values and counts of the SPI control block
// Assumes: Included by bare name from the design files
// Notes:   Definitions only
`ifndef SPI_CTRL_DEFINES_SVH
`define SPI_CTRL_DEFINES_SVH
// Register byte offsets on the AHB-Lite slave
`define OFS_PRIMARY      8'h00
`define OFS_SECONDARY    8'h04
`define OFS_STATUS       8'h08
`define OFS_DATA         8'h0C
`define OFS_BAUD         8'h10
// Primary control fields
`define B_RX_FAULT_IE    7
`define B_SYS_EN         6
`define B_TX_EMPTY_IE    5
`define B_MASTER         4
`define B_POLARITY       3
`define B_PHASE          2
`define B_SEL_OUT_EN     1
`define B_LSB_FIRST      0
// Secondary control fields
`define B_FAULT_DET_EN   4
`define B_SHARED_OE      3
`define B_WAIT_STOP      1
`define B_SINGLE_WIRE    0
`define SECONDARY_MASK   8'h1B
// Status fields
`define B_RX_FULL        7
`define B_TX_EMPTY       5
`define B_MODE_FAULT     4
// Reset values
`define PRIMARY_RST      8'h00
`define SECONDARY_RST    8'h00
`define BAUD_RST         8'h03
`define PIN_IN_RST       4'h8
// Serial clock edges in one byte
`define XFER_EDGES       5'h10
// Synchronised pin positions
`define PIN_SCK          0
`define PIN_MOSI         1
`define PIN_MISO         2
`define PIN_SS           3
`endif

// ===== inc/spi_ctrl_pkg.sv
// Purpose: Types shared by the SPI control block
// Assumes: Nothing beyond the defines header
// Notes:   State of each module is one packed struct
package spi_ctrl_pkg;
    typedef enum logic {ST_IDLE, ST_XFER} xfer_state_e;

    typedef struct packed {
        logic [7:0]  c1;
        logic [7:0]  c2;
        logic [7:0]  baud;
        logic [7:0]  txbuf;
        logic [7:0]  rxbuf;
        logic [7:0]  shreg;
        logic [7:0]  div_cnt;
        logic [4:0]  edge_cnt;
        logic        tx_full;
        logic        rx_full;
        logic        mode_fault_flag;
        logic        dout;
        logic        sclk_lvl;
        logic        sck_prev;
        logic        ss_prev;
        xfer_state_e state;
        logic        a_sel;
        logic        a_write;
        logic        rd_pend;
        logic [7:0]  a_addr;
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        irq;
        logic [3:0]  pin_o;
        logic [3:0]  pin_oe;
    } ctrl_state_s;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] q;
    } sync_state_s;
endpackage

// ===== hw/spi_pin_sync.sv
// Purpose: Three-stage synchroniser for the four serial pin inputs
// Assumes: Pins are asynchronous to hclk
// Notes:   Output follows only when stages two and three agree
`include "spi_ctrl_defines.svh"
module spi_pin_sync
    import spi_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Pins and filtered levels
    input  wire logic [3:0] pin_raw,
    output logic [3:0]      pin_q
);
    sync_state_s st_ff;
    sync_state_s nxt_st;

    // Stage one feeds stage two only; the agreement check ignores it
    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = pin_raw;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        nxt_st.q  = (st_ff.s3 & ~(st_ff.s2 ^ st_ff.s3)) | (st_ff.q & (st_ff.s2 ^ st_ff.s3));
    end

    // Slave select resets high so no select is seen out of reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '{s1: `PIN_IN_RST, s2: `PIN_IN_RST, s3: `PIN_IN_RST, q: `PIN_IN_RST};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pin_q = st_ff.q;
endmodule

// ===== test/spi_far_end.sv
// Purpose: Far-end SPI device, acting as slave or as master
// Assumes: The bench resolves the pins; data lines carry no pull
// Notes:   A released data line shows the inverse of its last value
module spi_far_end (
    // Mode
    input  wire logic       mst,
    input  wire logic       pol,
    input  wire logic       pha,
    input  wire logic       lsb,
    // Pins
    input  wire logic       sck_w,
    input  wire logic       ss_w,
    input  wire logic       din,
    output logic            dout,
    output logic            sck_d,
    output logic            ss_d,
    // Bytes
    input  wire logic [7:0] tx,
    output logic [7:0]      rx
);
    timeunit 1ns;
    timeprecision 1ps;
    int n = 0;
    initial begin
        dout = 1'b0;
        sck_d = 1'b0;
        ss_d = 1'b1;
        rx = 8'h00;
    end
    // Phase zero puts the first bit out before any clock edge
    always @(negedge ss_w) begin
        n = 0;
        if (!pha) dout = tx[lsb ? 0 : 7];
    end
    // Deselected: never leave the last bit standing
    always @(posedge ss_w) dout = ~dout;
    // Odd edges sample in phase zero, even ones in phase one
    always @(sck_w) begin
        if (!ss_w && n < 16) begin
            n++;
            if (n[0] ^ pha) rx[lsb ? (n-1)/2 : 7-(n-1)/2] = din;
            else if (n < 16) dout = tx[lsb ? n/2 : 7-n/2];
        end
    end
    // Master role: 160 ns link clock, running only inside the frame
    task automatic run_frame;
        #2; // Step off the bench clock edge
        sck_d = pol;
        ss_d = 1'b0;
        #80;
        repeat (16) begin
            sck_d = ~sck_d;
            #80;
        end
        ss_d = 1'b1;
    endtask
endmodule

// ===== test/test_spi_ctrl.sv
// Purpose: Self-checking bench for the SPI control block
// Assumes: AHB-Lite master model below; far device in spi_far_end
// Notes:   Baud value 7 gives the synchroniser room on the data lines
`include "spi_ctrl_defines.svh"
module test_spi_ctrl
    import spi_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, hsel, hwrite, wait_md, fss_n, mst, pol, pha, lsb;
    logic        hreadyout, hresp, irq, fdout, fsck, fss;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic [3:0]  pin_out, pin_oe, pin_in, ext;
    logic [7:0]  ftx, frx;
    int          error_cnt = 0;
    int          comparisons = 0;
    // Wire levels: a driven pin follows its driver, else the far side
    assign ext = {fss & fss_n, mst ? ~fdout : fdout, mst ? fdout : ~fdout, fsck};
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
    spi_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .cpu_wait_mode(wait_md), .irq(irq));
    spi_far_end far_u (.mst(mst), .pol(pol), .pha(pha), .lsb(lsb), .sck_w(pin_in[0]),
        .ss_w(pin_in[3]), .din(mst ? pin_in[2] : pin_in[1]), .dout(fdout),
        .sck_d(fsck), .ss_d(fss), .tx(ftx), .rx(frx));
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    task automatic finish_test;
        if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge hclk);
    endtask
    // Bounded wait for hready; a hang ends the run
    task automatic wait_rdy;
        int k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 40);
        if (hreadyout !== 1'b1) begin
            error_cnt++;
            finish_test;
        end
    endtask
    // One single transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a, d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy;
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(s, q, e);
    endtask
    // Poll a status bit, bounded by a read count
    task automatic poll(input int b);
        logic [31:0] q;
        int k;
        for (k = 0; k < 200; k++) begin
            bus(1'b0, `OFS_STATUS, 8'h00, q);
            if (q[b] === 1'b1) break;
        end
        chk("poll", k < 200, 1'b1);
        if (k == 200) finish_test;
    endtask
    task automatic t_reset;
        chk("oe rst", pin_oe, 4'h0);
        chk("irq rst", {irq, hresp}, 2'b00);
        rdc("c1 rst", `OFS_PRIMARY, 32'h0);
        wr(`OFS_SECONDARY, 8'hFF);
        rdc("c2 bits", `OFS_SECONDARY, 32'h1B);
        rdc("unmapped", 8'h40, 32'h0);
        wr(`OFS_SECONDARY, 8'h10);
        wr(`OFS_BAUD, 8'h07);
        rdc("baud", `OFS_BAUD, 32'h07);
    endtask
    // Every polarity, phase and bit order against the far slave
    task automatic t_master;
        for (int c = 0; c < 8; c++) begin
            {pol, pha, lsb} <= c[2:0];
            ftx <= 8'h3A ^ c[7:0];
            wr(`OFS_PRIMARY, {4'b0101, c[2], c[1], 1'b1, c[0]});
            cyc(4);
            chk("sck idle", pin_out[0], pol);
            chk("master oe", pin_oe, 4'hB);
            wr(`OFS_DATA, 8'hC5 + c[7:0]);
            rdc("tx moved", `OFS_STATUS, 32'h20);
            cyc(20);
            chk("ss auto", pin_out[3], 1'b0);
            poll(`B_RX_FULL);
            chk("far rx", frx, 8'hC5 + c[7:0]);
            rdc("dut rx", `OFS_DATA, 8'h3A ^ c[7:0]);
            chk("sck back", pin_out[0], pol);
        end
    endtask
    task automatic t_irq;
        wr(`OFS_PRIMARY, 8'h7F);
        cyc(2);
        chk("tx irq", irq, 1'b1);
        wr(`OFS_PRIMARY, 8'h50);
        cyc(2);
        chk("tx irq off", {irq, pin_oe[3]}, 2'b00);
        wr(`OFS_PRIMARY, 8'hD0);
        fss_n <= 1'b0;
        cyc(10);
        chk("fault irq", irq, 1'b1);
        rdc("fault flag", `OFS_STATUS, 32'h30);
        rdc("master drop", `OFS_PRIMARY, 32'hC0);
        fss_n <= 1'b1;
        cyc(6);
        wr(`OFS_STATUS, 8'h10);
        cyc(2);
        chk("fault clr", irq, 1'b0);
        wr(`OFS_SECONDARY, 8'h00);
        wr(`OFS_PRIMARY, 8'h52);
        cyc(2);
        chk("ss gpio", pin_oe[3], 1'b0);
    endtask
    task automatic t_pins;
        wr(`OFS_SECONDARY, 8'h08);
        cyc(2);
        chk("sep oe", pin_oe[2:1], 2'b01);
        wr(`OFS_SECONDARY, 8'h01);
        cyc(2);
        chk("mw in", pin_oe[2:1], 2'b00);
        wr(`OFS_SECONDARY, 8'h09);
        cyc(2);
        chk("mw out", pin_oe[2:1], 2'b01);
        wr(`OFS_PRIMARY, 8'h40);
        wr(`OFS_SECONDARY, 8'h19);
        cyc(2);
        chk("sw slave", pin_oe, 4'h4);
        wr(`OFS_SECONDARY, 8'h00);
    endtask
    // Far master drives a frame into the block as slave
    task automatic t_slave;
        {pol, pha, lsb} <= 3'b000;
        wr(`OFS_DATA, 8'h96);
        ftx <= 8'h69;
        mst <= 1'b1;
        cyc(2);
        far_u.run_frame;
        cyc(8);
        chk("far got", frx, 8'h96);
        rdc("slave rx", `OFS_DATA, 32'h69);
        mst <= 1'b0;
    endtask
    task automatic t_wait_dis;
        wr(`OFS_PRIMARY, 8'h52);
        wr(`OFS_SECONDARY, 8'h12);
        wr(`OFS_DATA, 8'h5A);
        // Freeze mid-byte so the engine really has a transfer to hold
        cyc(40);
        wait_md <= 1'b1;
        cyc(300);
        chk("frozen", {pin_out[3], pin_oe[0]}, 2'b01);
        rdc("frozen st", `OFS_STATUS, 32'h20);
        wait_md <= 1'b0;
        poll(`B_RX_FULL);
        chk("thawed", frx, 8'h5A);
        rdc("thaw rx", `OFS_DATA, 32'h69);
        wr(`OFS_DATA, 8'hE1);
        cyc(30);
        wr(`OFS_PRIMARY, 8'h12);
        rdc("disabled", `OFS_STATUS, 32'h20);
        chk("released", pin_oe, 4'h0);
        wr(`OFS_PRIMARY, 8'h52);
        cyc(200);
        rdc("no stale", `OFS_STATUS, 32'h20);
    endtask
    initial begin
        {hresetn, hsel, hwrite, wait_md, mst, pol, pha, lsb} = 8'h00;
        fss_n = 1'b1;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        ftx = 8'h00;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        cyc(2);
        t_reset;
        t_master;
        t_irq;
        t_pins;
        t_slave;
        t_wait_dis;
        finish_test;
    end
endmodule
